// ---- pwc_map.svh ----
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH
`define PWC_IDX_TIMERS      8'h45
`define PWC_IDX_PIN_CFG     8'h50
`define PWC_IDX_EN_A        8'h52
`define PWC_IDX_EN_B        8'h53
`define PWC_IDX_ST_A        8'h56
`define PWC_IDX_EN_C        8'h54
`define PWC_IDX_EN_D        8'h55
`define PWC_IDX_MODE_STAT   8'h40
`define PWC_EN_A_MASK       8'h76
`define PWC_EN_D_MASK       8'h7f
`define PWC_ST_A_MASK       8'h77
`define PWC_PIN_MASK        8'h0f
`define PWC_TIM_MASK        8'h3f
`define PWC_STEP_STAT_BIT   3
`define PWC_TICK_NS         125000000
`define PWC_CLK_NS          4
`define PWC_TICK_CYC        (`PWC_TICK_NS / `PWC_CLK_NS)
`define PWC_CODE_OFF        3'h0
`define PWC_CODE_RSVD       3'h7
`define PWC_SPD_8MHZ        3'h2
`endif

// ---- pwc_pkg.sv ----
package pwc_pkg;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pwc_req_t;
    typedef struct packed {
        logic       keypad;
        logic       sleep_tmr;
        logic       uart_rx;
        logic       uart_call;
        logic       rtc;
        logic       adapter;
        logic [2:0] battery;
        logic [7:0] prog_req;
        logic [6:0] socket;
    } pwc_src_t;
endpackage : pwc_pkg

// ---- pwc_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pwc_map.svh"
module pwc_timer (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [2:0] code_i,
    output logic            busy_o,
    output logic            done_o
);
    logic [31:0] tick_reg;
    logic [5:0]  ticks_reg;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            tick_reg  <= 32'h0;
            ticks_reg <= 6'h0;
        end else if (start_i) begin
            tick_reg <= 32'h0;
            if (code_i == `PWC_CODE_OFF || code_i == `PWC_CODE_RSVD) begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
            end else begin
                busy_o    <= 1'b1;
                done_o    <= 1'b0;
                ticks_reg <= 6'(6'h1 << (code_i - 3'h1));
            end
        end else if (busy_o) begin
            done_o <= 1'b0;
            if (tick_reg == 32'(`PWC_TICK_CYC - 1)) begin
                tick_reg <= 32'h0;
                if (ticks_reg == 6'h1) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                ticks_reg <= ticks_reg - 6'h1;
            end else begin
                tick_reg <= tick_reg + 32'h1;
            end
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule : pwc_timer
`default_nettype wire

// ---- pwc_wake.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pwc_map.svh"
module pwc_wake (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire pwc_pkg::pwc_req_t req_i,
    output logic [7:0]             rdata_o,
    input  wire logic              asleep_i,
    input  wire logic [2:0]        prog_speed_i,
    input  wire logic              susres_pin_i,
    input  wire logic              uart_receive_pin_i,
    input  wire logic              uart_call_indicator_i,
    input  wire logic              mains_adapter_sense_i,
    input  wire logic [2:0]        battery_low_i,
    input  wire logic              keypad_pressed_i,
    input  wire logic              rtc_alarm_i,
    input  wire logic              sleep_timer_expired_i,
    input  wire logic [7:0]        prog_req_i,
    input  wire logic [6:0]        socket_evt_i,
    output logic                   resume_o,
    output logic                   suspend_o,
    output logic                   run_levels_o,
    output logic                   io_enable_o,
    output logic [2:0]             cpu_speed_o,
    output logic                   step_timer_running_o
);
    import pwc_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_PAUSE = 4'b0010,
        ST_STEP  = 4'b0100,
        ST_RUN   = 4'b1000
    } pwc_state_t;

    function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
        edge_hit = (sel[0] & was & ~now) | (sel[1] & ~was & now);
    endfunction : edge_hit

    logic [7:0]  timers_reg, pin_cfg_reg, en_a_reg, en_b_reg, en_c_reg, en_d_reg, st_a_reg;
    logic [7:0]  st_b_reg, st_c_reg, st_d_reg;
    pwc_state_t  state_reg;
    logic [14:0] sync1_reg, sync2_reg, prev_reg;
    logic        key_armed_reg;
    pwc_src_t    hit;
    logic        any_wake, pin_rise, pin_fall, pin_res, pin_sus;
    logic        pause_busy, pause_done, step_busy, step_done, pause_go, step_go;

    // Two flops on every pin but the alarm, sleep timer and prog_req_i inputs before use; they keep sampling in reset so no false edge follows release
    always_ff @(posedge core_clk_i) begin
        sync1_reg <= {socket_evt_i, battery_low_i, mains_adapter_sense_i, uart_call_indicator_i,
                      uart_receive_pin_i, keypad_pressed_i, susres_pin_i};
        sync2_reg <= sync1_reg;
        prev_reg  <= sync2_reg;
    end

    assign pin_rise = sync2_reg[0] & ~prev_reg[0];
    assign pin_fall = ~sync2_reg[0] & prev_reg[0];

    always_comb begin
        pin_res = 1'b0;
        pin_sus = 1'b0;
        case (pin_cfg_reg[3:2])
            2'h0: begin
                pin_res = pin_rise & asleep_i;
                pin_sus = pin_rise & ~asleep_i;
            end
            2'h1: begin
                pin_res = pin_fall & asleep_i;
                pin_sus = pin_fall & ~asleep_i;
            end
            2'h2: begin
                pin_sus = pin_rise;
                pin_res = pin_fall;
            end
            default: begin
                pin_res = pin_rise;
                pin_sus = pin_fall;
            end
        endcase
        pin_res = pin_res & pin_cfg_reg[1] & asleep_i;
        pin_sus = pin_sus & pin_cfg_reg[0] & ~asleep_i;
    end

    // Wake source qualification
    always_comb begin
        hit.keypad    = en_a_reg[6] & key_armed_reg & sync2_reg[1];
        hit.sleep_tmr = en_a_reg[5] & sleep_timer_expired_i;
        hit.rtc       = en_a_reg[1] & rtc_alarm_i;
        hit.uart_rx   = en_a_reg[4] & prev_reg[2] & ~sync2_reg[2];
        hit.uart_call = en_a_reg[2] & prev_reg[3] & ~sync2_reg[3];
        hit.adapter   = edge_hit(en_b_reg[7:6], sync2_reg[4], prev_reg[4]);
        hit.battery[2] = edge_hit(en_b_reg[5:4], sync2_reg[7], prev_reg[7]);
        hit.battery[1] = edge_hit(en_b_reg[3:2], sync2_reg[6], prev_reg[6]);
        hit.battery[0] = edge_hit(en_b_reg[1:0], sync2_reg[5], prev_reg[5]);
        hit.prog_req  = en_c_reg & prog_req_i;
        hit.socket    = en_d_reg[6:0] & sync2_reg[14:8];
    end

    assign any_wake = asleep_i & (state_reg == ST_IDLE) & ((|hit) | pin_res);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            key_armed_reg <= 1'b1;
        end else if (any_wake && hit.keypad) begin
            key_armed_reg <= 1'b0;
        end else if (!sync2_reg[1]) begin
            key_armed_reg <= 1'b1;
        end
    end

    assign pause_go = any_wake;
    assign step_go  = (state_reg == ST_PAUSE) & pause_done;

    pwc_timer u_pause (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (pause_go),
        .code_i     (timers_reg[2:0]),
        .busy_o     (pause_busy),
        .done_o     (pause_done)
    );

    pwc_timer u_step (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (step_go),
        .code_i     (timers_reg[5:3]),
        .busy_o     (step_busy),
        .done_o     (step_done)
    );

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE:  if (any_wake) state_reg <= ST_PAUSE;
                ST_PAUSE: if (pause_done) state_reg <= ST_STEP;
                ST_STEP:  if (step_done) state_reg <= ST_RUN;
                ST_RUN:   if (asleep_i) state_reg <= ST_IDLE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            resume_o             <= 1'b0;
            suspend_o            <= 1'b0;
            run_levels_o         <= 1'b0;
            io_enable_o          <= 1'b1;
            cpu_speed_o          <= `PWC_SPD_8MHZ;
            step_timer_running_o <= 1'b0;
        end else begin
            resume_o     <= any_wake;
            suspend_o    <= pin_sus;
            if (any_wake) begin
                run_levels_o <= 1'b1;
            end else if (asleep_i && state_reg == ST_IDLE) begin
                run_levels_o <= 1'b0;
            end
            // Pins stay off whenever asleep, whatever the sequencer state
            io_enable_o  <= ~asleep_i & (state_reg != ST_PAUSE);
            step_timer_running_o <= step_busy;
            if (step_go) begin
                cpu_speed_o <= `PWC_SPD_8MHZ;
            end else if (step_done && prog_speed_i > `PWC_SPD_8MHZ) begin
                cpu_speed_o <= prog_speed_i;
            end else if (state_reg == ST_RUN && cpu_speed_o != prog_speed_i) begin
                cpu_speed_o <= prog_speed_i;
            end
        end
    end

    // Config registers; reset clears documented zero fields
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            timers_reg  <= 8'h00;
            pin_cfg_reg <= 8'h00;
            en_a_reg    <= 8'h00;
            en_b_reg    <= 8'h00;
            en_c_reg    <= 8'h00;
            en_d_reg    <= 8'h00;
        end else if (req_i.wr) begin
            if (req_i.idx == `PWC_IDX_TIMERS) begin
                timers_reg <= req_i.wdata & `PWC_TIM_MASK;
            end else if (req_i.idx == `PWC_IDX_PIN_CFG) begin
                pin_cfg_reg <= req_i.wdata & `PWC_PIN_MASK;
            end else if (req_i.idx == `PWC_IDX_EN_A) begin
                en_a_reg <= req_i.wdata & `PWC_EN_A_MASK;
            end else if (req_i.idx == `PWC_IDX_EN_B) begin
                en_b_reg <= req_i.wdata;
            end else if (req_i.idx == `PWC_IDX_EN_C) begin
                en_c_reg <= req_i.wdata;
            end else if (req_i.idx == `PWC_IDX_EN_D) begin
                en_d_reg <= req_i.wdata & `PWC_EN_D_MASK;
            end
        end
    end

    // Status: set wins over write-zero clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // undefined reset, cleared here for determinism
            st_a_reg <= 8'h00;
        end else begin
            if (req_i.wr && req_i.idx == `PWC_IDX_ST_A) begin
                st_a_reg <= (st_a_reg & req_i.wdata & `PWC_ST_A_MASK) | ({8{any_wake}} &
                            {1'b0, hit.keypad, hit.sleep_tmr, hit.uart_rx, 1'b0, hit.uart_call, hit.rtc, pin_res});
            end else if (any_wake) begin
                // keypad status, receive status, timer status
                st_a_reg <= st_a_reg |
                            {1'b0, hit.keypad, hit.sleep_tmr, hit.uart_rx, 1'b0, hit.uart_call, hit.rtc, pin_res};
            end
        end
    end

    // Sibling status kept internal for sources outside this map
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_b_reg <= 8'h00;
            st_c_reg <= 8'h00;
            st_d_reg <= 8'h00;
        end else if (any_wake) begin
            st_b_reg <= st_b_reg | {1'b0, hit.adapter, 1'b0, hit.battery[2], 1'b0, hit.battery[1],
                                    1'b0, hit.battery[0]};
            st_c_reg <= st_c_reg | hit.prog_req;
            st_d_reg <= st_d_reg | {1'b0, hit.socket};
        end
    end

    // Index/data read port
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            if (req_i.idx == `PWC_IDX_TIMERS) begin
                rdata_o <= timers_reg;
            end else if (req_i.idx == `PWC_IDX_PIN_CFG) begin
                rdata_o <= pin_cfg_reg;
            end else if (req_i.idx == `PWC_IDX_EN_A) begin
                rdata_o <= en_a_reg;
            end else if (req_i.idx == `PWC_IDX_EN_B) begin
                rdata_o <= en_b_reg;
            end else if (req_i.idx == `PWC_IDX_EN_C) begin
                rdata_o <= en_c_reg;
            end else if (req_i.idx == `PWC_IDX_EN_D) begin
                rdata_o <= en_d_reg;
            end else if (req_i.idx == `PWC_IDX_ST_A) begin
                rdata_o <= st_a_reg;
            end else if (req_i.idx == `PWC_IDX_MODE_STAT) begin
                rdata_o <= 8'(step_timer_running_o) << `PWC_STEP_STAT_BIT;
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end
endmodule : pwc_wake
`default_nettype wire

// ---- pwc_wake_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwc_wake_assertions (
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire pwc_pkg::pwc_req_t req_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              asleep_i,
    input wire logic              rtc_alarm_i,
    input wire logic              resume_o,
    input wire logic              io_enable_o,
    input wire logic [2:0]        cpu_speed_o,
    input wire logic              step_timer_running_o
);
    import pwc_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    logic rtc_en_reg;
    // Only the alarm enable is mirrored; other sources are judged by the bench
    always_ff @(posedge core_clk_i) begin
        if (rst_i) rtc_en_reg <= 1'b0;
        else if (req_i.wr && req_i.idx == 8'h52) rtc_en_reg <= req_i.wdata[1];
    end
    sequence pin_s;
        req_i.wr && req_i.idx == 8'h50 ##1 req_i.rd && req_i.idx == 8'h50;
    endsequence
    // Awake for three cycles, so no late wake can set a status bit
    sequence clr_s;
        !asleep_i ##1 !asleep_i && req_i.wr && req_i.idx == 8'h56 && req_i.wdata == 8'h00
        ##1 !asleep_i && req_i.rd && req_i.idx == 8'h56;
    endsequence
    unmap_rd_a: assert property (req_i.rd && req_i.idx == 8'h57 |=> rdata_o == 8'h00)
        else $error("unmapped read");
    pin_rd_a: assert property (pin_s |=> rdata_o == ($past(req_i.wdata, 2) & 8'h0f))
        else $error("pin config readback");
    step_rd_a: assert property (req_i.rd && req_i.idx == 8'h40 |=>
        rdata_o == {4'h0, $past(step_timer_running_o), 3'h0}) else $error("step status read");
    res_cause_a: assert property (resume_o |-> $past(asleep_i))
        else $error("resume while awake");
    rtc_wake_a: assert property ($rose(rtc_alarm_i) && asleep_i && rtc_en_reg |-> ##[0:2] resume_o)
        else $error("alarm did not wake");
    io_off_a: assert property (asleep_i [*2] |-> !io_enable_o)
        else $error("io enabled asleep");
    step_slow_a: assert property (step_timer_running_o |-> cpu_speed_o == 3'h2)
        else $error("step not at 8 MHz");
    clr_rd_a: assert property (clr_s |=> rdata_o == 8'h00)
        else $error("status clear");
endmodule : pwc_wake_assertions
bind pwc_wake pwc_wake_assertions chk_u (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .req_i(req_i),
    .rdata_o(rdata_o),
    .asleep_i(asleep_i),
    .rtc_alarm_i(rtc_alarm_i),
    .resume_o(resume_o),
    .io_enable_o(io_enable_o),
    .cpu_speed_o(cpu_speed_o),
    .step_timer_running_o(step_timer_running_o)
);
`default_nettype wire

// ---- pwc_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwc_src_model (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        sleep_i,
    input  wire logic        go_i,
    input  wire logic [4:0]  code_i,
    input  wire logic        resume_i,
    output logic             asleep_o,
    output logic [7:0]       lv_o,
    output logic [16:0]      pv_o
);
    initial begin
        asleep_o = 1'b0;
        lv_o = 8'h3f;
        pv_o = '0;
    end
    // PMU leaves Suspend once it sees the wake pulse
    always @(posedge core_clk_i) begin
        if (rst_i) asleep_o <= 1'b0;
        else if (sleep_i) asleep_o <= 1'b1;
        else if (resume_i) asleep_o <= 1'b0;
    end
    always @(posedge core_clk_i) begin
        if (rst_i) lv_o <= 8'h3f;
        else if (go_i && code_i < 5'd8) lv_o[code_i[2:0]] <= ~lv_o[code_i[2:0]];
    end
    always @(posedge core_clk_i) begin
        if (rst_i || sleep_i) pv_o <= '0;
        else if (go_i && code_i >= 5'd8) pv_o <= 17'h1 << (code_i - 5'd8);
    end
endmodule : pwc_src_model
`default_nettype wire

// ---- pwc_wake_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwc_wake_bench;
    import pwc_pkg::*;
    logic        clk, rst, sl, go, resume, suspend, runl, ioen, steprun, asleep;
    logic [4:0]  code;
    logic [2:0]  spd, cpu;
    logic [7:0]  rdata, lv, d;
    logic [16:0] pv;
    pwc_req_t    req;
    logic [7:0]  exp_q[$];
    int          failures, cmp_count, res_n, sus_n;
    logic [7:0]  ens[5] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h50};
    logic [7:0]  rix[6] = '{8'h45, 8'h50, 8'h52, 8'h53, 8'h54, 8'h55};
    logic [7:0]  rmk[6] = '{8'h3f, 8'h0f, 8'h76, 8'hff, 8'hff, 8'h7f};
    // Index, enable, status, then code, asleep and wake expected
    logic [31:0] cs[28] = '{32'h52101003, 32'h5204040b, 32'h52000002, 32'h5204000a,
        32'h52020243, 32'h5220204b, 32'h5200004a, 32'h53800012, 32'h53800013, 32'h53400013,
        32'h53c00013, 32'h5330002b, 32'h53040023, 32'h5302001a, 32'h5300001a, 32'h5002013b,
        32'h5001003a, 32'h500a003a, 32'h500a013b, 32'h50050038, 32'h50050039, 32'h500d0038,
        32'h500d0039, 32'h52404033, 32'h524000fa, 32'h52400032, 32'h52404033, 32'h5401005a};
    pwc_wake dut_u (
        .core_clk_i(clk),
        .rst_i(rst),
        .req_i(req),
        .rdata_o(rdata),
        .asleep_i(asleep),
        .prog_speed_i(spd),
        .susres_pin_i(lv[7]),
        .uart_receive_pin_i(lv[0]),
        .uart_call_indicator_i(lv[1]),
        .mains_adapter_sense_i(lv[2]),
        .battery_low_i(lv[5:3]),
        .keypad_pressed_i(lv[6]),
        .rtc_alarm_i(pv[0]),
        .sleep_timer_expired_i(pv[1]),
        .prog_req_i(pv[9:2]),
        .socket_evt_i(pv[16:10]),
        .resume_o(resume),
        .suspend_o(suspend),
        .run_levels_o(runl),
        .io_enable_o(ioen),
        .cpu_speed_o(cpu),
        .step_timer_running_o(steprun)
    );
    pwc_src_model src_u (
        .core_clk_i(clk),
        .rst_i(rst),
        .sleep_i(sl),
        .go_i(go),
        .code_i(code),
        .resume_i(resume),
        .asleep_o(asleep),
        .lv_o(lv),
        .pv_o(pv)
    );
    task automatic chk(input string nm, input logic [7:0] s, e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // On a read the data argument is the value expected back
    task automatic bus(input logic [7:0] ix, dt, input logic w, r);
        #1 req = '{ix, dt, w, r};
        if (r) exp_q.push_back(dt);
        @(posedge clk);
    endtask : bus
    task automatic rst_pulse();
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
    endtask : rst_pulse
    task automatic wk(input logic [7:0] ix, v, input logic [4:0] c, input logic s, w, input logic [7:0] st);
        int r0, s0;
        foreach (ens[i]) bus(ens[i], 8'h00, 1'b1, 1'b0);
        bus(8'h56, 8'h00, 1'b1, 1'b0);
        bus(8'h56, 8'h00, 1'b0, 1'b1);
        bus(ix, v, 1'b1, 1'b0);
        bus(8'h00, 8'h00, 1'b0, 1'b0);
        r0 = res_n;
        s0 = sus_n;
        #1 sl = s;
        @(posedge clk);
        #1 sl = 1'b0;
        go = 1'b1;
        code = c;
        @(posedge clk);
        #1 go = 1'b0;
        repeat (16) @(posedge clk);
        chk("resume", 8'(res_n - r0), s ? w : 1'b0);
        chk("suspend", 8'(sus_n - s0), s ? 1'b0 : w);
        bus(8'h56, st, 1'b0, 1'b1);
        bus(8'h00, 8'h00, 1'b0, 1'b0);
    endtask : wk
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #50000;
        failures++;
        wrap_up();
    end
    always @(posedge clk) begin
        if (resume === 1'b1) res_n++;
        if (suspend === 1'b1) sus_n++;
        if (req.rd === 1'b1) begin
            #1 chk("rdata", rdata, exp_q.pop_front());
        end
    end
    initial begin
        req = '0;
        sl = 1'b0;
        go = 1'b0;
        code = 5'd0;
        spd = 3'h5;
        rst = 1'b1;
        void'($urandom(32'h4f04));
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        foreach (rix[i]) bus(rix[i], 8'h00, 1'b0, 1'b1);
        bus(8'h56, 8'h00, 1'b0, 1'b1);
        foreach (rix[i]) begin
            d = 8'($urandom()) & rmk[i];
            bus(rix[i], d, 1'b1, 1'b0);
            bus(rix[i], d, 1'b0, 1'b1);
        end
        bus(8'h57, 8'hff, 1'b1, 1'b0);
        bus(8'h57, 8'h00, 1'b0, 1'b1);
        bus(8'h40, 8'h00, 1'b0, 1'b1);
        bus(8'h45, 8'h00, 1'b1, 1'b0);
        foreach (cs[i]) wk(cs[i][31:24], cs[i][23:16], cs[i][7:3], cs[i][1], cs[i][0], cs[i][15:8]);
        for (int k = 0; k < 15; k++) wk(k < 8 ? 8'h54 : 8'h55, 8'(1 << (k % 8)), 5'(10 + k), 1'b1, 1'b1, 8'h00);
        bus(8'h45, 8'h01, 1'b1, 1'b0);
        wk(8'h52, 8'h02, 5'd8, 1'b1, 1'b1, 8'h02);
        chk("io_en", ioen, 1'b0);
        chk("run_lv", runl, 1'b1);
        rst_pulse();
        bus(8'h45, 8'h08, 1'b1, 1'b0);
        wk(8'h52, 8'h02, 5'd8, 1'b1, 1'b1, 8'h02);
        chk("cpu", cpu, 3'h2);
        chk("step", steprun, 1'b1);
        bus(8'h40, 8'h08, 1'b0, 1'b1);
        rst_pulse();
        wk(8'h52, 8'h02, 5'd8, 1'b1, 1'b1, 8'h02);
        chk("cpu", cpu, 3'h5);
        chk("step", steprun, 1'b0);
        chk("io_en", ioen, 1'b1);
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule : pwc_wake_bench
`default_nettype wire
